// >>> verilog/acr_regs.sv
`timescale 1ns/1ps
module acr_regs
  import acr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wrStart,
  input  wire logic        wrStb,
  input  wire logic [7:0]  wrData,
  input  wire logic        rdStart,
  input  wire logic        rdStb,
  input  wire logic        convStart,
  input  wire logic        convDone,
  input  wire logic [11:0] convValue,
  input  wire logic        convViolation,
  output      logic [7:0]  rdData,
  output      logic        rdValid,
  output      logic        convBusy,
  output      logic [2:0]  convChannel,
  output      logic        alertPin,
  output      logic        busGlitchFilterEnable,
  output      logic        alertClear
);

  acr_regs_type cur_ff;
  acr_regs_type nxt_st;

  // next selected channel above the last one, wrapping to the lowest
  function automatic logic [2:0] next_chan(input logic [7:0] sel, input logic [2:0] last);
    logic [2:0] idx;
    logic       found;
    next_chan = last;
    found     = 1'b0;
    for (int k = 1; k <= 8; k++) begin
      idx = last + k[2:0];
      if (!found && sel[idx]) begin
        next_chan = idx;
        found     = 1'b1;
      end
    end
  endfunction : next_chan

  function automatic logic pin_level(input logic [15:0] cfg, input logic busy, input logic hit);
    logic act;
    unique case (cfg[CFG_FUNC_LO +: 2])
      FUNC_BUSY:  act = busy;
      FUNC_LIMIT: act = hit;
      FUNC_NONE:  act = 1'b0;
      FUNC_CLEAR: act = 1'b0;
    endcase
    pin_level = cfg[CFG_POL_BIT] ? act : ~act;
  endfunction : pin_level

  logic [7:0]  chanSel;
  logic [15:0] rdWord;
  logic [15:0] wrWord;
  logic        cfgCommit;
  logic        clearCode;
  logic        doneNow;
  logic [11:0] resMask;

  assign chanSel   = cur_ff.cfg[CFG_SEL_LO +: 8];
  assign wrWord    = {cur_ff.hiByte, wrData};
  assign cfgCommit = wrStb && (cur_ff.wrIdx == WR_LOW) && (cur_ff.ptr[3:0] == PTR_CONFIG);
  assign clearCode = cfgCommit && (wrWord[CFG_FUNC_LO +: 2] == FUNC_CLEAR);
  assign doneNow   = convDone && (cur_ff.state == ACR_CONV);
  assign resMask   = (RESULT_BITS == 10) ? RES_10BIT_MASK : RES_12BIT_MASK;

  always_comb begin
    unique case (cur_ff.ptr[3:0])
      PTR_RESULT: rdWord = {cur_ff.resFlag, cur_ff.resTag, cur_ff.resVal};
      PTR_CONFIG: rdWord = cur_ff.cfg;
      default:    rdWord = 16'h0000;
    endcase
  end

  always_comb begin
    nxt_st         = cur_ff;
    nxt_st.clr     = 1'b0;
    nxt_st.rdValid = 1'b0;

    // write side: pointer byte, then high/low data pairs
    if (wrStart) begin
      nxt_st.wrIdx = WR_POINTER;
    end else if (wrStb) begin
      unique case (cur_ff.wrIdx)
        WR_POINTER: begin
          nxt_st.ptr   = wrData;
          nxt_st.wrIdx = WR_HIGH;
        end
        WR_HIGH: begin
          nxt_st.hiByte = wrData;
          nxt_st.wrIdx  = WR_LOW;
        end
        default: begin
          nxt_st.wrIdx = WR_HIGH;
          if (cfgCommit) begin
            nxt_st.cfg = wrWord & CFG_USED_MASK;
            if (clearCode) begin
              // clear code acts once; pin function stays as before
              nxt_st.cfg[CFG_FUNC_LO +: 2] = cur_ff.cfg[CFG_FUNC_LO +: 2];
              nxt_st.clr      = 1'b1;
              nxt_st.limitHit = 1'b0;
              nxt_st.resFlag  = 1'b0;
            end
          end
        end
      endcase
    end

    // read side: high byte first, then low byte
    if (rdStart) begin
      nxt_st.rdIdx = 1'b0;
    end else if (rdStb) begin
      nxt_st.rdData  = cur_ff.rdIdx ? rdWord[7:0] : rdWord[15:8];
      nxt_st.rdValid = 1'b1;
      nxt_st.rdIdx   = ~cur_ff.rdIdx;
    end

    // conversion sequencer
    unique case (cur_ff.state)
      ACR_IDLE: begin
        if (convStart && (chanSel != 8'h00)) begin
          nxt_st.chan  = next_chan(chanSel, cur_ff.chan);
          nxt_st.busy  = 1'b1;
          nxt_st.state = ACR_CONV;
        end
      end
      ACR_CONV: begin
        if (convDone) begin
          nxt_st.busy    = 1'b0;
          nxt_st.state   = ACR_IDLE;
          nxt_st.resTag  = cur_ff.chan;
          nxt_st.resVal  = convValue & resMask;
          nxt_st.resFlag = convViolation;
          if (convViolation) begin
            nxt_st.limitHit = 1'b1;
          end
        end
      end
    endcase

    nxt_st.pin = pin_level(nxt_st.cfg, nxt_st.busy, nxt_st.limitHit);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '{state:    ACR_IDLE,
                  ptr:      PTR_RESET,
                  cfg:      CFG_RESET,
                  wrIdx:    WR_POINTER,
                  hiByte:   8'h00,
                  rdIdx:    1'b0,
                  rdData:   8'h00,
                  rdValid:  1'b0,
                  chan:     CHAN_RESET,
                  busy:     1'b0,
                  limitHit: 1'b0,
                  resFlag:  1'b0,
                  resTag:   3'h0,
                  resVal:   12'h000,
                  // reset function is limit, active low, no hit: pin starts inactive
                  pin:      1'b1,
                  clr:      1'b0};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign rdData                = cur_ff.rdData;
  assign rdValid               = cur_ff.rdValid;
  assign convBusy              = cur_ff.busy;
  assign convChannel           = cur_ff.chan;
  assign alertPin              = cur_ff.pin;
  assign busGlitchFilterEnable = cur_ff.cfg[CFG_BUS_GLITCH_FILTER_ENABLE_BIT];
  assign alertClear            = cur_ff.clr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_ptr_load: assert property (wrStb && !wrStart && cur_ff.wrIdx == WR_POINTER |=> cur_ff.ptr == $past(wrData))
    else $error("pointer not loaded from first write byte");

  a_clear_code: assert property (clearCode && !wrStart && !doneNow
                                 |=> alertClear && !cur_ff.limitHit && !cur_ff.resFlag ##1 !alertClear)
    else $error("clear code did not clear indicator and flag");

  a_pin_level: assert property (alertPin == pin_level(cur_ff.cfg, convBusy, cur_ff.limitHit))
    else $error("indicator pin disagrees with function and polarity");

  a_busy_pin: assert property (cur_ff.cfg[CFG_FUNC_LO +: 2] == FUNC_BUSY && convBusy
                               |-> alertPin == cur_ff.cfg[CFG_POL_BIT])
    else $error("busy pin not active during conversion");

  a_seq_pick: assert property (cur_ff.state == ACR_IDLE && convStart && chanSel != 8'h00
                               |=> convBusy && cur_ff.cfg[CFG_SEL_LO + convChannel])
    else $error("converting an unselected channel");

  a_result_tag: assert property (doneNow |=> !convBusy && cur_ff.resTag == $past(convChannel)
                                 && cur_ff.resFlag == $past(convViolation))
    else $error("result tag or flag not taken from conversion");

  a_read_high: assert property (rdStb && !rdStart && !cur_ff.rdIdx
                                |=> rdValid && rdData == $past(rdWord[15:8]) ##1 $past(rdStb) || !rdValid)
    else $error("first result byte wrong");

  a_low_bits: assert property (RESULT_BITS != 10 || cur_ff.resVal[1:0] == 2'h0)
    else $error("10-bit result low bits not zero");

  a_filter_bit: assert property (cfgCommit && !wrStart |=> busGlitchFilterEnable == $past(wrData[CFG_BUS_GLITCH_FILTER_ENABLE_BIT]))
    else $error("filter enable not following written bit");

  c_cfg_write: cover property (cfgCommit && !clearCode);
  c_clear:     cover property (clearCode);
  c_conv_done: cover property (doneNow && convViolation);
  c_two_reads: cover property (rdStb && !cur_ff.rdIdx ##1 rdStb);

endmodule : acr_regs

// >>> verilog/acr_pkg.sv
// Overview of operation
// - set channel bit adds input to conversion set
// - bit four is input one, bit eleven input eight
// - selected channels converted in turn, lowest first
// - bit three enables bus glitch filter
// - bit two turns limit indicator on
// - bits two, one pick pin function
// - writing 11 clears pin, flag, alert status
// - bit zero sets pin active level
// - reset: filter and limit enable set, rest zero
// - result is 16-bit read-only, two byte read
// - first byte flag, tag, result high bits
// - result follows tag, msb first, 12/10 bits
// - 10-bit variant: two lsbs read zero
// - channel tag is input number minus one
// - flag shows violation of that tagged result
// - first written byte loads register pointer
package acr_pkg;
  localparam logic [3:0]  PTR_RESULT      = 4'h0;
  localparam logic [3:0]  PTR_CONFIG      = 4'h2;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam logic [15:0] CFG_RESET       = 16'h000C;
  localparam logic [15:0] CFG_USED_MASK   = 16'h0FFF;
  localparam int          CFG_SEL_LO      = 4;
  localparam int          CFG_BUS_GLITCH_FILTER_ENABLE_BIT    = 3;
  localparam int          CFG_FUNC_LO     = 1;
  localparam int          CFG_POL_BIT     = 0;
  localparam logic [1:0]  FUNC_NONE       = 2'h0;
  localparam logic [1:0]  FUNC_BUSY       = 2'h1;
  localparam logic [1:0]  FUNC_LIMIT      = 2'h2;
  localparam logic [1:0]  FUNC_CLEAR      = 2'h3;
  localparam int          RESULT_BITS     = 12;
  localparam logic [11:0] RES_10BIT_MASK  = 12'hFFC;
  localparam logic [11:0] RES_12BIT_MASK  = 12'hFFF;
  localparam logic [2:0]  CHAN_RESET      = 3'h7;
  localparam logic [1:0]  WR_POINTER      = 2'h0;
  localparam logic [1:0]  WR_HIGH         = 2'h1;
  localparam logic [1:0]  WR_LOW          = 2'h2;

  typedef enum logic [0:0] {
    ACR_IDLE = 1'b0,
    ACR_CONV = 1'b1
  } acr_state_type;

  typedef struct packed {
    acr_state_type state;
    logic [7:0]    ptr;
    logic [15:0]   cfg;
    logic [1:0]    wrIdx;
    logic [7:0]    hiByte;
    logic          rdIdx;
    logic [7:0]    rdData;
    logic          rdValid;
    logic [2:0]    chan;
    logic          busy;
    logic          limitHit;
    logic          resFlag;
    logic [2:0]    resTag;
    logic [11:0]   resVal;
    logic          pin;
    logic          clr;
  } acr_regs_type;
endpackage : acr_pkg

// >>> bench/acr_host_model.sv
`timescale 1ns/1ps
module acr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid,
  output      logic       wrStart,
  output      logic       wrStb,
  output      logic [7:0] wrData,
  output      logic       rdStart,
  output      logic       rdStb
);
  initial begin
    {wrStart, wrStb, rdStart, rdStb} = 4'h0;
    wrData = 8'h00;
  end
  // one byte slot; released data shows the inverse, not a stale value
  task automatic put(input logic s, input logic [7:0] d);
    @(negedge clk);
    {wrStart, wrStb} = {s, !s};
    wrData = d;
    @(negedge clk);
    {wrStart, wrStb} = 2'h0;
    wrData = ~d;
  endtask : put
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] v);
    put(1'b1, 8'h00);
    put(1'b0, p);
    put(1'b0, v[15:8]);
    put(1'b0, v[7:0]);
  endtask : wr_reg
  task automatic get(output logic [7:0] d);
    int n;
    @(negedge clk);
    rdStb = 1'b1;
    @(negedge clk);
    rdStb = 1'b0;
    for (n = 0; n < 4 && rdValid !== 1'b1; n++) @(negedge clk);
    d = rdData;
  endtask : get
  // pointer written first, then two bytes read, high byte first
  task automatic rd_reg(input logic [7:0] p, output logic [15:0] v);
    put(1'b1, 8'h00);
    put(1'b0, p);
    @(negedge clk);
    rdStart = 1'b1;
    @(negedge clk);
    rdStart = 1'b0;
    get(v[15:8]);
    get(v[7:0]);
  endtask : rd_reg
endmodule : acr_host_model

// >>> bench/adc_config_and_result_regs_tb.sv
`timescale 1ns/1ps
module adc_config_and_result_regs_tb;
  import acr_pkg::*;
  logic        clk, arst_n, wrStart, wrStb, rdStart, rdStb, rdValid;
  logic        convStart, convDone, convViolation, convBusy, alertPin;
  logic        busGlitchFilterEnable, alertClear;
  logic [7:0]  wrData, rdData;
  logic [11:0] convValue;
  logic [2:0]  convChannel;
  logic [15:0] r;
  int          errTotal = 0;
  int          checkCount = 0;
  int          cycleCount = 0;

  acr_regs u_acr_regs (.clk(clk), .arst_n(arst_n), .wrStart(wrStart), .wrStb(wrStb), .wrData(wrData),
    .rdStart(rdStart), .rdStb(rdStb), .convStart(convStart), .convDone(convDone), .convValue(convValue),
    .convViolation(convViolation), .rdData(rdData), .rdValid(rdValid), .convBusy(convBusy),
    .convChannel(convChannel), .alertPin(alertPin), .busGlitchFilterEnable(busGlitchFilterEnable),
    .alertClear(alertClear));
  acr_host_model u_acr_host_model (.clk(clk), .rdData(rdData), .rdValid(rdValid), .wrStart(wrStart),
    .wrStb(wrStb), .wrData(wrData), .rdStart(rdStart), .rdStb(rdStb));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000) begin
      errTotal++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one conversion; pin level checked mid-conversion, result read back after
  task automatic conv(input logic [2:0] tag, input logic [11:0] v, input logic vio, input logic pinMid);
    logic [15:0] res;
    @(negedge clk);
    convStart = 1'b1;
    @(negedge clk);
    convStart = 1'b0;
    check({15'h0, convBusy}, 16'h0001);
    check({13'h0, convChannel}, {13'h0, tag});
    repeat (2) @(negedge clk);
    check({15'h0, alertPin}, {15'h0, pinMid});
    {convValue, convViolation, convDone} = {v, vio, 1'b1};
    @(negedge clk);
    {convValue, convDone} = {~v, 1'b0};
    repeat (2) @(negedge clk);
    check({15'h0, convBusy}, 16'h0000);
    u_acr_host_model.rd_reg({4'h0, PTR_RESULT}, res);
    check(res, {vio, tag, (RESULT_BITS == 10) ? (v & RES_10BIT_MASK) : v});
  endtask : conv

  initial begin
    arst_n = 1'b0;
    {convStart, convDone, convViolation} = 3'h0;
    convValue = 12'h000;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    u_acr_host_model.rd_reg({4'h0, PTR_CONFIG}, r);
    check(r, 16'h000C);
    check({15'h0, busGlitchFilterEnable}, 16'h0001);
    // inputs one, three and six in limit mode, active low; unused channels zero
    u_acr_host_model.wr_reg({4'h0, PTR_CONFIG}, 16'hF254);
    u_acr_host_model.rd_reg({4'h0, PTR_CONFIG}, r);
    check(r, 16'h0254);
    check({15'h0, busGlitchFilterEnable}, 16'h0000);
    u_acr_host_model.rd_reg(8'h05, r);
    check(r, 16'h0000);
    conv(3'h0, 12'hABC, 1'b0, 1'b1);
    conv(3'h2, 12'h123, 1'b1, 1'b1);
    conv(3'h5, 12'h3FF, 1'b0, 1'b0);
    conv(3'h0, 12'h001, 1'b0, 1'b0);
    u_acr_host_model.wr_reg({4'h0, PTR_CONFIG}, 16'h0256);
    check({15'h0, alertPin}, 16'h0001);
    check({15'h0, alertClear}, 16'h0001);
    @(negedge clk);
    check({15'h0, alertClear}, 16'h0000);
    u_acr_host_model.rd_reg({4'h0, PTR_RESULT}, r);
    check({15'h0, r[15]}, 16'h0000);
    u_acr_host_model.rd_reg({4'h0, PTR_CONFIG}, r);
    check(r, 16'h0254);
    // busy function, active high, input one only
    u_acr_host_model.wr_reg({4'h0, PTR_CONFIG}, 16'h0013);
    conv(3'h0, 12'hFFF, 1'b0, 1'b1);
    check({15'h0, alertPin}, 16'h0000);
    // no pin function: violation leaves the pin inactive
    u_acr_host_model.wr_reg({4'h0, PTR_CONFIG}, 16'h0010);
    conv(3'h0, 12'h555, 1'b1, 1'b1);
    check({15'h0, alertPin}, 16'h0001);
    // no channel selected: start request is refused
    u_acr_host_model.wr_reg({4'h0, PTR_CONFIG}, 16'h000C);
    @(negedge clk);
    convStart = 1'b1;
    @(negedge clk);
    convStart = 1'b0;
    @(negedge clk);
    check({15'h0, convBusy}, 16'h0000);
    stop_test();
  end
endmodule : adc_config_and_result_regs_tb
